// *** hw/rst_pwr_pkg.sv ***
package rst_pwr_pkg;
  localparam logic [7:0] reg_ctrl       = 8'h00;
  localparam logic [7:0] reg_pwr        = 8'h04;
  localparam logic [7:0] reg_status     = 8'h08;
  localparam logic [7:0] reg_hotswap    = 8'h0c;
  localparam int         bit_ds_rst     = 0;
  localparam int         bit_chip_rst   = 1;
  localparam int         bit_mask_done  = 2;
  localparam int         bit_ins_event  = 0;
  localparam int         bit_ext_req    = 1;
  localparam int         bit_led        = 2;
  localparam logic [1:0] pwr_d0         = 2'h0;
  localparam logic [1:0] pwr_d1         = 2'h1;
  localparam logic [1:0] pwr_d2         = 2'h2;
  localparam logic [1:0] pwr_d3hot      = 2'h3;
  localparam int         blackout_clks  = 16;
  localparam int         chip_rst_clks  = 20;
  localparam int         sync_stages    = 2;
endpackage

// *** hw/reset_sync.sv ***
`timescale 1ns/1ps
// async assert, sync release; first stage only feeds the second
module reset_sync
  import rst_pwr_pkg::*;
(
  // clock and raw reset
  input  wire logic clk,
  input  wire logic arst_n,
  // synchronised reset
  output logic      srst_n
);
  logic [sync_stages-1:0] chain_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[sync_stages-2:0], 1'b1};
    end
  end

  assign srst_n = chain_r[sync_stages-1];
endmodule

// *** hw/bridge_reset_power_sequencer.sv ***
`timescale 1ns/1ps
module bridge_reset_power_sequencer
  import rst_pwr_pkg::*;
#(
  parameter int AD_W = 32
) (
  // clock and upstream reset
  input  wire logic            mclk,
  input  wire logic            resetn,
  // downstream reset pin sensed
  input  wire logic            ds_rst_pin_n,
  input  wire logic            clock_gating_permit_pin,
  // register port
  input  wire logic [7:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic [31:0]          rdata,
  // gating of accesses and buses
  output logic                 access_ok,
  output logic                 us_float,
  output logic                 ds_float,
  output logic                 buf_clear,
  output logic                 chip_rst_n,
  // downstream pins
  output logic                 ds_rst_n,
  output logic                 downstream_clock_en,
  output logic [AD_W-1:0]      downstream_addr_data,
  output logic [3:0]           downstream_cmd_byte_en_n,
  output logic                 downstream_parity,
  output logic                 ds_drive_oe_n,
  // hot swap
  output logic                 hot_swap_enum_n,
  output logic                 removal_ready_led
);
  logic       sresetn;
  logic [4:0] blackout_r;
  logic [4:0] chip_cnt_r;
  logic       chip_busy_r;
  logic       ds_rst_bit_r;
  logic       mask_done_r;
  logic [1:0] pwr_r;
  logic       soft_rst_r;
  logic       ins_r;
  logic       ext_r;
  logic       led_r;
  logic       ds_pin_s1_r;
  logic       ds_pin_s2_r;
  logic       wr_pwr;
  logic [1:0] wr_state;
  logic       ds_rst_req;
  logic [4:0] since_rel_r;

  // upstream reset: async assert, sync release
  reset_sync u_rsync (
    .clk    (mclk),
    .arst_n (resetn),
    .srst_n (sresetn)
  );

  // downstream pin sensed asynchronously, so synchronise it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ds_pin_s1_r <= 1'b1;
      ds_pin_s2_r <= 1'b1;
    end else begin
      ds_pin_s1_r <= ds_rst_pin_n;
      ds_pin_s2_r <= ds_pin_s1_r;
    end
  end

  assign wr_pwr   = wr && access_ok && addr == reg_pwr;
  assign wr_state = wdata[1:0];
  // bus reset stays on during chip reset until the clock mask is in
  assign ds_rst_req = ds_rst_bit_r || (chip_busy_r && !mask_done_r);

  // blackout after upstream reset release
  always_ff @(posedge mclk or negedge sresetn) begin
    if (!sresetn) begin
      blackout_r <= 5'(blackout_clks);
    end else if (blackout_r != 5'h00) begin
      blackout_r <= blackout_r - 5'h01;
    end
  end

  // power state; D1/D2 writes leave state alone
  always_ff @(posedge mclk or negedge sresetn) begin
    if (!sresetn) begin
      pwr_r      <= pwr_d0;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= 1'b0;
      if (wr_pwr) begin
        if (wr_state == pwr_d3hot) begin
          pwr_r <= pwr_d3hot;
        end else if (wr_state == pwr_d0 && pwr_r == pwr_d3hot) begin
          pwr_r      <= pwr_d0;
          soft_rst_r <= 1'b1;
        end
      end
    end
  end

  // chip reset sequencing; also triggered by D3hot to D0
  always_ff @(posedge mclk or negedge sresetn) begin
    if (!sresetn) begin
      chip_busy_r  <= 1'b0;
      chip_cnt_r   <= 5'h00;
      ds_rst_bit_r <= 1'b0;
      mask_done_r  <= 1'b0;
    end else if (wr && access_ok && addr == reg_ctrl &&
                 wdata[bit_chip_rst]) begin
      chip_busy_r  <= 1'b1;
      ds_rst_bit_r <= 1'b1;
      mask_done_r  <= 1'b0;
      chip_cnt_r   <= 5'(chip_rst_clks);
    end else if (soft_rst_r) begin
      chip_busy_r <= 1'b1;
      chip_cnt_r  <= 5'(chip_rst_clks);
      mask_done_r <= 1'b1;
    end else begin
      // the ctrl register stays writable so software can end the reset
      if (wr && addr == reg_ctrl && blackout_r == 5'h00) begin
        ds_rst_bit_r <= wdata[bit_ds_rst];
        if (wdata[bit_mask_done]) begin
          mask_done_r <= 1'b1;
        end
      end
      if (chip_busy_r && !ds_rst_bit_r && mask_done_r) begin
        // the bit drops on the twentieth counted edge, not one later
        if (chip_cnt_r > 5'h01) begin
          chip_cnt_r <= chip_cnt_r - 5'h01;
        end else begin
          chip_busy_r <= 1'b0;
        end
      end
    end
  end

  // hot swap indicators, software owned
  always_ff @(posedge mclk or negedge sresetn) begin
    if (!sresetn) begin
      ins_r <= 1'b0;
      ext_r <= 1'b0;
      led_r <= 1'b0;
    end else if (wr && access_ok && addr == reg_hotswap) begin
      ins_r <= wdata[bit_ins_event];
      ext_r <= wdata[bit_ext_req];
      led_r <= wdata[bit_led];
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge sresetn) begin
    if (!sresetn) begin
      access_ok                <= 1'b0;
      us_float                 <= 1'b1;
      ds_float                 <= 1'b1;
      buf_clear                <= 1'b1;
      chip_rst_n               <= 1'b0;
      ds_rst_n                 <= 1'b0;
      downstream_clock_en      <= 1'b1;
      downstream_addr_data     <= '0;
      downstream_cmd_byte_en_n <= 4'h0;
      downstream_parity        <= 1'b0;
      ds_drive_oe_n            <= 1'b0;
      hot_swap_enum_n          <= 1'b1;
      removal_ready_led        <= 1'b0;
      rdata                    <= 32'h0000_0000;
    end else begin
      // bus reset from the bit alone does not block access
      access_ok  <= blackout_r == 5'h00 && !chip_busy_r;
      us_float   <= chip_busy_r;
      ds_float   <= chip_busy_r || ds_rst_bit_r || !ds_pin_s2_r;
      buf_clear  <= chip_busy_r || ds_rst_bit_r || !ds_pin_s2_r;
      chip_rst_n <= !chip_busy_r;
      ds_rst_n   <= !ds_rst_req;
      downstream_clock_en <= !(pwr_r == pwr_d3hot &&
                               clock_gating_permit_pin);
      // pins held low; drivers enabled only while reset is on
      downstream_addr_data     <= '0;
      downstream_cmd_byte_en_n <= 4'h0;
      downstream_parity        <= 1'b0;
      ds_drive_oe_n <= !(ds_rst_req || !ds_pin_s2_r);
      hot_swap_enum_n   <= !(ins_r || ext_r);
      removal_ready_led <= led_r;
      rdata <= 32'h0000_0000;
      if (rd && access_ok) begin
        unique case (addr)
          reg_ctrl:    rdata <= {29'h0, mask_done_r, chip_busy_r,
                                 ds_rst_bit_r};
          reg_pwr:     rdata <= {30'h0, pwr_r};
          reg_status:  rdata <= {30'h0, ~ds_pin_s2_r,
                                 ~downstream_clock_en};
          reg_hotswap: rdata <= {29'h0, led_r, ext_r, ins_r};
          default:     rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // no power-management event input exists, nothing is forwarded

  // assertions
  sequence s_chip_req;
    wr && access_ok && addr == reg_ctrl && wdata[bit_chip_rst];
  endsequence

  property p_blackout;
    @(posedge mclk) disable iff (!sresetn)
      $rose(sresetn) |-> !access_ok [*8];
  endproperty
  a_blackout: assert property (p_blackout) else $error("early access");

  property p_chip_sets_ds;
    @(posedge mclk) disable iff (!sresetn)
      s_chip_req |=> ##1 (!ds_rst_n && !access_ok && us_float);
  endproperty
  a_chip_sets_ds: assert property (p_chip_sets_ds)
    else $error("chip reset effects missing");

  property p_no_access_busy;
    @(posedge mclk) disable iff (!sresetn)
      chip_busy_r |=> !access_ok;
  endproperty
  a_no_access_busy: assert property (p_no_access_busy)
    else $error("access during chip reset");

  property p_chip_ends;
    @(posedge mclk) disable iff (!sresetn)
      (chip_busy_r && !ds_rst_bit_r && mask_done_r && !soft_rst_r)
        |-> ##[1:20] !chip_busy_r;
  endproperty
  a_chip_ends: assert property (p_chip_ends)
    else $error("chip reset not cleared");

  property p_d12_ignored;
    @(posedge mclk) disable iff (!sresetn)
      (wr_pwr && (wr_state == pwr_d1 || wr_state == pwr_d2))
        |=> $stable(pwr_r);
  endproperty
  a_d12_ignored: assert property (p_d12_ignored)
    else $error("D1/D2 accepted");

  property p_clk_gate;
    @(posedge mclk) disable iff (!sresetn)
      (pwr_r == pwr_d3hot && clock_gating_permit_pin)
        |=> !downstream_clock_en;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock not gated");

  property p_wake;
    @(posedge mclk) disable iff (!sresetn)
      (wr_pwr && wr_state == pwr_d0 && pwr_r == pwr_d3hot && !ds_rst_bit_r)
        |=> ##1 (chip_busy_r && ds_rst_n);
  endproperty
  a_wake: assert property (p_wake) else $error("wake sequence wrong");

  property p_ds_low;
    @(posedge mclk) disable iff (!sresetn)
      !ds_rst_n |-> (downstream_addr_data == '0 && !downstream_parity
                     && downstream_cmd_byte_en_n == 4'h0
                     && !ds_drive_oe_n);
  endproperty
  a_ds_low: assert property (p_ds_low) else $error("bus not low");

  property p_bit_access;
    @(posedge mclk) disable iff (!sresetn)
      (ds_rst_bit_r && !chip_busy_r && blackout_r == 5'h00)
        |=> access_ok;
  endproperty
  a_bit_access: assert property (p_bit_access)
    else $error("blocked by bus reset bit");

  property p_enum;
    @(posedge mclk) disable iff (!sresetn)
      (ins_r || ext_r) |=> !hot_swap_enum_n;
  endproperty
  a_enum: assert property (p_enum) else $error("enum not driven");

  // cycles since release, kept apart from the blackout counter it checks
  always_ff @(posedge mclk or negedge sresetn) begin
    if (!sresetn) begin
      since_rel_r <= 5'h00;
    end else if (since_rel_r != '1) begin
      since_rel_r <= since_rel_r + 5'h01;
    end
  end

  property p_blackout_long;
    @(posedge mclk) disable iff (!sresetn)
      (since_rel_r < 5'(blackout_clks)) |-> !access_ok;
  endproperty
  a_blackout_long: assert property (p_blackout_long)
    else $error("access inside blackout");

  property p_busy_float;
    @(posedge mclk) disable iff (!sresetn)
      chip_busy_r |=> (us_float && ds_float && buf_clear && !chip_rst_n);
  endproperty
  a_busy_float: assert property (p_busy_float)
    else $error("chip reset not applied");

  sequence s_mask_pending;
    chip_busy_r && !mask_done_r;
  endsequence

  property p_ds_rst_held;
    @(posedge mclk) disable iff (!sresetn)
      s_mask_pending |=> !ds_rst_n;
  endproperty
  a_ds_rst_held: assert property (p_ds_rst_held)
    else $error("bus reset dropped before mask");

  property p_pin_float;
    @(posedge mclk) disable iff (!sresetn)
      !ds_pin_s2_r |=> (ds_float && !ds_drive_oe_n);
  endproperty
  a_pin_float: assert property (p_pin_float)
    else $error("pin reset did not float bus");

  property p_buf_clear;
    @(posedge mclk) disable iff (!sresetn)
      !ds_rst_n |-> buf_clear;
  endproperty
  a_buf_clear: assert property (p_buf_clear)
    else $error("buffers kept during bus reset");

  property p_pwr_legal;
    @(posedge mclk) disable iff (!sresetn)
      (pwr_r != pwr_d1 && pwr_r != pwr_d2);
  endproperty
  a_pwr_legal: assert property (p_pwr_legal)
    else $error("unsupported power state held");

  property p_d3_entry;
    @(posedge mclk) disable iff (!sresetn)
      (wr_pwr && wr_state == pwr_d3hot) |=> (pwr_r == pwr_d3hot);
  endproperty
  a_d3_entry: assert property (p_d3_entry)
    else $error("D3hot write lost");

  property p_d0_clock;
    @(posedge mclk) disable iff (!sresetn)
      (pwr_r == pwr_d0) |=> downstream_clock_en;
  endproperty
  a_d0_clock: assert property (p_d0_clock)
    else $error("clock stopped in D0");

  property p_led;
    @(posedge mclk) disable iff (!sresetn)
      1'b1 |=> (removal_ready_led == $past(led_r));
  endproperty
  a_led: assert property (p_led) else $error("led not following");

  property p_enum_off;
    @(posedge mclk) disable iff (!sresetn)
      !(ins_r || ext_r) |=> hot_swap_enum_n;
  endproperty
  a_enum_off: assert property (p_enum_off)
    else $error("enum active with no event");
endmodule

// *** tb/ds_agent_model.sv ***
`timescale 1ns/1ps
// downstream agent sharing the pulled-up reset line
module ds_agent_model (
  // request from bench
  input  wire logic mclk,
  input  wire logic hold_rst,
  // reset line, pulled up while released
  output logic      ds_rst_pin_n
);
  initial ds_rst_pin_n = 1'b1;
  // moves off the clock edge so the sync path sees an unrelated edge
  always @(posedge mclk) begin
    #1.7 ds_rst_pin_n = !hold_rst;
  end
endmodule

// *** tb/bridge_reset_power_sequencer_tb.sv ***
`timescale 1ns/1ps
module bridge_reset_power_sequencer_tb;
  import rst_pwr_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        clock_gating_permit_pin = 1'b1;
  logic        hold_rst = 1'b0;
  logic        ds_rst_pin_n;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic        access_ok, us_float, ds_float, buf_clear, chip_rst_n;
  logic        ds_rst_n, downstream_clock_en, downstream_parity;
  logic        ds_drive_oe_n, hot_swap_enum_n, removal_ready_led;
  logic [31:0] downstream_addr_data;
  logic [3:0]  downstream_cmd_byte_en_n;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;

  always #2.5 mclk = ~mclk;

  bridge_reset_power_sequencer bridge_reset_power_sequencer_inst (
    .mclk(mclk), .resetn(resetn), .ds_rst_pin_n(ds_rst_pin_n),
    .clock_gating_permit_pin(clock_gating_permit_pin),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .access_ok(access_ok), .us_float(us_float), .ds_float(ds_float),
    .buf_clear(buf_clear), .chip_rst_n(chip_rst_n), .ds_rst_n(ds_rst_n),
    .downstream_clock_en(downstream_clock_en),
    .downstream_addr_data(downstream_addr_data),
    .downstream_cmd_byte_en_n(downstream_cmd_byte_en_n),
    .downstream_parity(downstream_parity), .ds_drive_oe_n(ds_drive_oe_n),
    .hot_swap_enum_n(hot_swap_enum_n),
    .removal_ready_led(removal_ready_led));

  ds_agent_model ds_agent_model_inst (
    .mclk(mclk), .hold_rst(hold_rst), .ds_rst_pin_n(ds_rst_pin_n));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // bounded wait for the block to take accesses again
  task automatic wait_ok(input int lim);
    int n;
    n = 0;
    while (access_ok !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    #1;
  endtask

  task automatic t_power_on();
    tick(2);
    check("us_float", 32'(us_float), 1);
    check("chip_rst_n", 32'(chip_rst_n), 0);
    check("ds_rst_n", 32'(ds_rst_n), 0);
    @(posedge mclk) resetn <= 1'b1;
    wr_reg(reg_hotswap, 32'h0000_0004);
    repeat (15) begin
      #1 check("access_ok", 32'(access_ok), 0);
      @(posedge mclk);
    end
    wait_ok(40);
    check("ds_rst_n", 32'(ds_rst_n), 1);
    check("led", 32'(removal_ready_led), 0);
  endtask

  task automatic t_hotswap();
    wr_reg(reg_hotswap, 32'h0000_0001);
    tick(2);
    check("enum_n", 32'(hot_swap_enum_n), 0);
    wr_reg(reg_hotswap, 32'h0000_0002);
    tick(2);
    check("enum_n", 32'(hot_swap_enum_n), 0);
    wr_reg(reg_hotswap, 32'h0000_0004);
    tick(2);
    check("enum_n", 32'(hot_swap_enum_n), 1);
    check("led", 32'(removal_ready_led), 1);
  endtask

  task automatic t_ds_bit();
    wr_reg(reg_ctrl, 32'h0000_0001);
    tick(2);
    check("ds_rst_n", 32'(ds_rst_n), 0);
    check("oe_n", 32'(ds_drive_oe_n), 0);
    check("buf_clear", 32'(buf_clear), 1);
    rd_reg(reg_ctrl);
    check("ctrl", d & 32'h0000_0001, 1);
    check("access_ok", 32'(access_ok), 1);
    wr_reg(reg_ctrl, 32'h0000_0000);
    tick(2);
    check("ds_rst_n", 32'(ds_rst_n), 1);
  endtask

  task automatic t_pin();
    hold_rst <= 1'b1;
    tick(4);
    check("ds_float", 32'(ds_float), 1);
    check("oe_n", 32'(ds_drive_oe_n), 0);
    check("ad", downstream_addr_data | 32'(downstream_parity), 0);
    check("cbe", 32'(downstream_cmd_byte_en_n), 0);
    check("buf_clear", 32'(buf_clear), 1);
    rd_reg(reg_status);
    check("status", d & 32'h0000_0002, 32'h0000_0002);
    hold_rst <= 1'b0;
    tick(4);
    check("ds_float", 32'(ds_float), 0);
  endtask

  task automatic t_chip();
    wr_reg(reg_ctrl, 32'h0000_0002);
    tick(2);
    check("us_float", 32'(us_float), 1);
    check("ds_rst_n", 32'(ds_rst_n), 0);
    check("access_ok", 32'(access_ok), 0);
    rd_reg(reg_pwr);
    check("refused rd", d, 0);
    check("ds_rst_n", 32'(ds_rst_n), 0);
    wr_reg(reg_ctrl, 32'h0000_0000);
    tick(2);
    check("ds_rst_n", 32'(ds_rst_n), 0);
    wr_reg(reg_ctrl, 32'h0000_0004);
    tick(21);
    check("access_ok", 32'(access_ok), 1);
    check("chip_rst_n", 32'(chip_rst_n), 1);
    check("ds_rst_n", 32'(ds_rst_n), 1);
    rd_reg(reg_ctrl);
    check("ctrl", d & 32'h0000_0007, 32'h0000_0004);
  endtask

  task automatic t_power();
    for (int p = 1; p < 3; p++) begin
      wr_reg(reg_pwr, 32'(p));
      rd_reg(reg_pwr);
      check("pwr", d, 32'(pwr_d0));
    end
    for (int g = 1; g >= 0; g--) begin
      @(posedge mclk) clock_gating_permit_pin <= g[0];
      wr_reg(reg_pwr, 32'(pwr_d3hot));
      tick(2);
      check("clock_en", 32'(downstream_clock_en), 32'(!g[0]));
      rd_reg(reg_status);
      check("status", d & 32'h0000_0001, 32'(g[0]));
      wr_reg(reg_pwr, 32'(pwr_d0));
      tick(2);
      check("clock_en", 32'(downstream_clock_en), 1);
      check("chip_rst_n", 32'(chip_rst_n), 0);
      check("ds_rst_n", 32'(ds_rst_n), 1);
      wait_ok(40);
      rd_reg(reg_ctrl);
      check("ctrl", d & 32'h0000_0003, 0);
    end
  endtask

  task automatic t_async();
    @(posedge mclk) #1.3 resetn <= 1'b0;
    #0.5 check("ds_rst_n", 32'(ds_rst_n), 0);
    check("access_ok", 32'(access_ok), 0);
    check("led", 32'(removal_ready_led), 0);
    check("enum_n", 32'(hot_swap_enum_n), 1);
    @(posedge mclk) resetn <= 1'b1;
    wait_ok(40);
    check("access_ok", 32'(access_ok), 1);
  endtask

  initial begin
    t_power_on();
    t_hotswap();
    t_ds_bit();
    t_pin();
    t_chip();
    t_power();
    t_async();
    finish_test();
  end
endmodule
